// ### rtl/mcs_sequencer.sv
// pin sequencer of a microprogram control unit: eight intervals per cycle
// assumes: pins synchronised here, register port on the same clock
//
// Overview of operation
// - eight intervals per cycle, phases active only in odd intervals
// - command bus carries a nibble in odd intervals, zero in even ones
// - first interval: A-bus source, zero clears A; top bit low enables stack
// - third interval: low three bits give B-bus source register
// - third interval: top bit says A-bus is inverted onto IA-bus
// - fifth interval: low two bits ALU operation, upper two control
// - seventh interval: low three bits give R-bus destination register
// - seventh interval: top bit picks I/O multiplexer over shifter
// - eight data lines captured into latch bits zero to seven in interval seven
// - latch bit eight loaded from jump condition input in interval seven
// - jump/flag address driven on low data lines only in interval one
// - enable line driven high in intervals two to four on fetch branch
// - enable seen high in two to four: fetch, disable if not implemented
// - flag strobe low in interval two sets, in six resets
// - condition driven in intervals one and two, sampled there
// - conditional branch taken only when sampled condition is low
// - circular shift joins high and low lines in intervals seven, eight
// - circular left: low follows high; right: high follows low
// - open shift drives one on low (left) or high (right) line
// - carry-in driven on low line in intervals four and five
// - high line driven in interval one as flag update enable
// - high line precharged in two, must read one in three
// - high line released in intervals four and five
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module mcs_sequencer
   import mcs_pkg::*;
(
   // clock, reset, enable
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   // phases and commands
   output logic [3:0] phaseN,
   output logic [3:0] commandBusN,
   // data lines
   input wire logic [3:0] dataFlagAddrIn,
   output mcs_bus4_t dataFlagAddrOut,
   input wire logic [3:0] dataExtensionIn,
   // control lines
   input wire logic jumpConditionN,
   input wire logic multiUnitEnableIn,
   output mcs_pin_t multiUnitEnableOut,
   output logic flagStrobeN,
   // carry and shift lines
   input wire logic highCarryShiftIn,
   output mcs_pin_t highCarryShiftOut,
   input wire logic lowCarryShiftIn,
   output mcs_pin_t lowCarryShiftOut
);

   localparam logic [5:0] IVL_LAST = 6'(`MCS_IVL_CYC - 1);

   // interval membership
   function automatic logic ivIn(
      input mcs_ival_t iv,
      input mcs_ival_t lo,
      input mcs_ival_t hi
   );
      ivIn = (iv >= lo) && (iv <= hi);
   endfunction

   // registers
   logic [15:0] cmdQ;
   logic [15:0] ctrlQ;
   logic [8:0] ilatchQ;
   logic [15:0] rdataQ;
   logic fetchSeenQ;
   logic hiErrQ;
   logic condTakenQ;
   logic enabledQ;
   mcs_ival_t ivalQ;
   mcs_ival_t ivalD;
   logic [5:0] cntQ;
   logic [5:0] cntD;

   // synchronisers
   logic [11:0] syncA_q;
   logic [11:0] syncB_q;
   wire logic [11:0] pinsRaw;
   wire logic [3:0] diS;
   wire logic [3:0] extS;
   wire logic jcnS;
   wire logic mueS;
   wire logic hiS;
   wire logic loS;

   // registered pin drive
   logic [3:0] phaseQ;
   logic [3:0] cmdBusQ;
   logic diOeQ;
   logic mueOeQ;
   logic flagQ;
   mcs_pin_t hiQ;
   mcs_pin_t loQ;

   assign pinsRaw = {dataExtensionIn, dataFlagAddrIn, jumpConditionN,
                     multiUnitEnableIn, highCarryShiftIn, lowCarryShiftIn};
   assign {extS, diS, jcnS, mueS, hiS, loS} = syncB_q;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         syncA_q <= 12'h000;
         syncB_q <= 12'h000;
      end else if (ce) begin
         syncA_q <= pinsRaw;
         syncB_q <= syncA_q;
      end
   end

   // control fields
   wire logic run = ctrlQ[`MCS_B_RUN];
   wire logic setF = ctrlQ[`MCS_B_SETF];
   wire logic rstF = ctrlQ[`MCS_B_RSTF];
   wire logic ownFetch = ctrlQ[`MCS_B_FETCH];
   wire logic condBr = ctrlQ[`MCS_B_CBR];
   wire logic shEn = ctrlQ[`MCS_B_SHEN];
   wire logic circ = ctrlQ[`MCS_B_CIRC];
   wire logic right = ctrlQ[`MCS_B_RIGHT];
   wire logic carryIn = ctrlQ[`MCS_B_CIN];
   wire logic ovcEn = ctrlQ[`MCS_B_OVCEN];
   wire logic impl = ctrlQ[`MCS_B_IMPL];
   wire logic [3:0] jAddr = ctrlQ[`MCS_F_JADDR];

   // interval decode
   wire logic isT1 = (ivalQ == IV_T1);
   wire logic isT2 = (ivalQ == IV_T2);
   wire logic isT3 = (ivalQ == IV_T3);
   wire logic isT6 = (ivalQ == IV_T6);
   wire logic isT7 = (ivalQ == IV_T7);
   wire logic isT4to5 = ivIn(ivalQ, IV_T4, IV_T5);
   wire logic isT2to4 = ivIn(ivalQ, IV_T2, IV_T4);
   wire logic isT7to8 = ivIn(ivalQ, IV_T7, IV_T8);
   wire logic oddIval = isT1 | isT3 | (ivalQ == IV_T5) | isT7;

   // interval timer
   wire logic step = ce & run & enabledQ;
   wire logic ivalEnd = step && (cntQ == IVL_LAST);

   assign cntD = ivalEnd ? 6'h00 : cntQ + 6'h01;

   always_comb begin
      unique case (ivalQ)
         IV_T1: ivalD = IV_T2;
         IV_T2: ivalD = IV_T3;
         IV_T3: ivalD = IV_T4;
         IV_T4: ivalD = IV_T5;
         IV_T5: ivalD = IV_T6;
         IV_T6: ivalD = IV_T7;
         IV_T7: ivalD = IV_T8;
         IV_T8: ivalD = IV_T1;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cntQ <= 6'h00;
         ivalQ <= IV_T1;
      end else if (step) begin
         cntQ <= cntD;
         if (ivalEnd) begin
            ivalQ <= ivalD;
         end
      end
   end

   wire logic [3:0] phaseD = oddIval ? ~(4'h1 << ivalQ[2:1]) : 4'hf;

   wire logic [3:0] cmdNibble = isT1 ? cmdQ[3:0] :
                                isT3 ? cmdQ[7:4] :
                                (ivalQ == IV_T5) ? cmdQ[11:8] :
                                isT7 ? cmdQ[15:12] : 4'h0;

   wire logic [3:0] cmdBusD = oddIval ? ~cmdNibble : 4'h0;

   wire logic diOeD = ~isT1;

   wire logic mueOeD = ~(isT2to4 & ownFetch);

   wire logic flagD = ~((isT2 & setF) | (isT6 & rstF));

   // shift window
   wire logic shWin = shEn & isT7to8;
   wire logic hiShDrv = shWin & right;
   wire logic loShDrv = shWin & ~right;

   // flag update enable in first interval
   // circular join in seven and eight
   mcs_pin_t hiD;
   assign hiD.oeN = ~(isT1 | isT2 | isT6 | hiShDrv);
   assign hiD.val = isT1 ? ovcEn : (hiShDrv & circ) ? loS : 1'b1;

   mcs_pin_t loD;
   assign loD.oeN = ~(isT4to5 | isT6 | loShDrv);
   assign loD.val = isT4to5 ? carryIn : (loShDrv & circ) ? hiS : 1'b1;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         phaseQ <= 4'hf;
         cmdBusQ <= 4'h0;
         diOeQ <= 1'b1;
         mueOeQ <= 1'b1;
         flagQ <= 1'b1;
         hiQ <= '{val: 1'b1, oeN: 1'b1};
         loQ <= '{val: 1'b1, oeN: 1'b1};
      end else if (ce) begin
         phaseQ <= phaseD;
         cmdBusQ <= cmdBusD;
         diOeQ <= diOeD;
         mueOeQ <= mueOeD;
         flagQ <= flagD;
         hiQ <= hiD;
         loQ <= loD;
      end
   end

   assign phaseN = phaseQ;
   assign commandBusN = cmdBusQ;
   assign dataFlagAddrOut.val = jAddr;
   assign dataFlagAddrOut.oeN = {4{diOeQ}};
   assign multiUnitEnableOut.val = 1'b1;
   assign multiUnitEnableOut.oeN = mueOeQ;
   assign flagStrobeN = flagQ;
   assign highCarryShiftOut = hiQ;
   assign lowCarryShiftOut = loQ;

   // sampling events
   wire logic endT2 = ivalEnd & isT2;
   wire logic endT3 = ivalEnd & isT3;
   wire logic endT4 = ivalEnd & (ivalQ == IV_T4);
   wire logic endT7 = ivalEnd & isT7;
   wire logic otherFetch = endT4 & mueS & ~ownFetch;
   wire logic hiBad = endT3 & ~hiS;

   // register port decode
   wire logic wrCmd = ce & regWr & (regAddr == `MCS_ADDR_CMD);
   wire logic wrCtrl = ce & regWr & (regAddr == `MCS_ADDR_CTRL);
   wire logic wrStat = ce & regWr & (regAddr == `MCS_ADDR_STAT);
   wire logic clrFetch = wrStat & regWdata[`MCS_B_FETCHSEEN];
   wire logic clrHiErr = wrStat & regWdata[`MCS_B_HIERR];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cmdQ <= `MCS_CMD_RST;
         ctrlQ <= `MCS_CTRL_RST;
      end else begin
         if (wrCmd) begin
            cmdQ <= regWdata;
         end
         if (wrCtrl) begin
            ctrlQ <= regWdata;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ilatchQ <= 9'h000;
      end else if (endT7) begin
         ilatchQ <= {jcnS, extS, diS};
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         condTakenQ <= 1'b0;
      end else if (endT2) begin
         condTakenQ <= condBr & ~jcnS;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         enabledQ <= 1'b1;
         fetchSeenQ <= 1'b0;
      end else if (ce) begin
         if (otherFetch & ~impl) begin
            enabledQ <= 1'b0;
         end else if (wrCtrl & regWdata[`MCS_B_RUN]) begin
            enabledQ <= 1'b1;
         end
         if (otherFetch | (ivalEnd & isT2to4 & ownFetch)) begin
            fetchSeenQ <= 1'b1;
         end else if (clrFetch) begin
            fetchSeenQ <= 1'b0;
         end
      end
   end

   // high line must read one in T3
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hiErrQ <= 1'b0;
      end else if (hiBad) begin
         hiErrQ <= 1'b1;
      end else if (clrHiErr) begin
         hiErrQ <= 1'b0;
      end
   end

   // read path
   wire logic [15:0] statWord = {9'h000, ivalQ, enabledQ, condTakenQ, hiErrQ, fetchSeenQ};
   wire logic [15:0] rdMux = (regAddr == `MCS_ADDR_CMD) ? cmdQ :
                             (regAddr == `MCS_ADDR_CTRL) ? ctrlQ :
                             (regAddr == `MCS_ADDR_STAT) ? statWord :
                             (regAddr == `MCS_ADDR_ILATCH) ? {7'h00, ilatchQ} : 16'h0000;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdataQ <= 16'h0000;
      end else if (ce) begin
         rdataQ <= regRd ? rdMux : 16'h0000;
      end
   end

   assign regRdata = rdataQ;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence sTick(logic c);
      ce && c;
   endsequence

   sequence sEnd(logic c);
      ivalEnd && c;
   endsequence

   AST_WRAP: assert property (
      sEnd(ivalQ == IV_T8) |=> ivalQ == IV_T1)
      else $error("interval did not wrap to T1");

   AST_PHASE_EVEN: assert property (
      sTick(!oddIval) |=> phaseN == 4'hf)
      else $error("phase active in even interval");

   AST_CMD_EVEN: assert property (
      sTick(!oddIval) |=> commandBusN == 4'h0)
      else $error("command bus not zero in even interval");

   AST_CMD_T3: assert property (
      sTick(isT3) |=> commandBusN == ~$past(cmdQ[7:4]))
      else $error("wrong B-bus command");

   AST_CMD_T7: assert property (
      sTick(isT7) |=> commandBusN == ~$past(cmdQ[15:12]))
      else $error("wrong R-bus command");

   AST_DI_OUT: assert property (
      sTick(1'b1) |=> (dataFlagAddrOut.oeN == {4{!$past(isT1)}}))
      else $error("address drive outside T1");

   AST_LATCH: assert property (
      sEnd(isT7) |=> ilatchQ == $past({jcnS, extS, diS}))
      else $error("instruction latch not loaded");

   AST_MUE: assert property (
      sTick(isT2to4 && ownFetch) |=> !multiUnitEnableOut.oeN && multiUnitEnableOut.val)
      else $error("enable line not driven on fetch");

   AST_DISABLE: assert property (
      sEnd(ivalQ == IV_T4 && mueS && !ownFetch && !impl) |=> !enabledQ && fetchSeenQ)
      else $error("unit not disabled on foreign fetch");

   AST_FLAG_SET: assert property (
      sTick(isT2 && setF) |=> !flagStrobeN)
      else $error("flag set strobe missing");

   AST_FLAG_IDLE: assert property (
      sTick(!setF && !rstF) |=> flagStrobeN)
      else $error("flag strobe low with no request");

   AST_COND: assert property (
      sEnd(isT2) |=> condTakenQ == $past(condBr && !jcnS))
      else $error("branch decision wrong");

   AST_CIRC_LEFT: assert property (
      sTick(shWin && circ && !right) |=> !lowCarryShiftOut.oeN
         && lowCarryShiftOut.val == $past(hiS))
      else $error("low line not following high");

   AST_OPEN_RIGHT: assert property (
      sTick(shWin && !circ && right) |=> !highCarryShiftOut.oeN && highCarryShiftOut.val)
      else $error("open right shift not driving one");

   AST_CARRY: assert property (
      sTick(isT4to5) |=> !lowCarryShiftOut.oeN && lowCarryShiftOut.val == $past(carryIn))
      else $error("carry-in not driven");

   AST_HI_T1: assert property (
      sTick(isT1) |=> !highCarryShiftOut.oeN && highCarryShiftOut.val == $past(ovcEn))
      else $error("flag update enable not driven");

   AST_PRECHARGE: assert property (
      sTick(isT2) |=> !highCarryShiftOut.oeN && highCarryShiftOut.val)
      else $error("high line not precharged");

   AST_HI_REL: assert property (
      sTick(isT4to5) |=> highCarryShiftOut.oeN)
      else $error("high line driven in T4 or T5");

endmodule

`default_nettype wire

// ### rtl/mcs_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes: included once by the package and by the bench
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// offsets on the register port
`define MCS_ADDR_CMD 4'h0
`define MCS_ADDR_CTRL 4'h1
`define MCS_ADDR_STAT 4'h2
`define MCS_ADDR_ILATCH 4'h3

// reset values
`define MCS_CMD_RST 16'h0000
`define MCS_CTRL_RST 16'h0000

// control fields
`define MCS_B_RUN 0
`define MCS_B_SETF 1
`define MCS_B_RSTF 2
`define MCS_B_FETCH 3
`define MCS_B_CBR 4
`define MCS_B_SHEN 5
`define MCS_B_CIRC 6
`define MCS_B_RIGHT 7
`define MCS_B_CIN 8
`define MCS_B_OVCEN 9
`define MCS_B_IMPL 10
`define MCS_F_JADDR 15:12

// status fields
`define MCS_B_FETCHSEEN 0
`define MCS_B_HIERR 1
`define MCS_B_CONDTAKEN 2
`define MCS_B_ENABLED 3
`define MCS_F_IVAL 6:4

// timing
`define MCS_T_INTERVAL_NS 250
`define MCS_CLK_NS 4
`define MCS_IVL_CYC ((`MCS_T_INTERVAL_NS + `MCS_CLK_NS - 1) / `MCS_CLK_NS)

`endif

// ### rtl/mcs_pkg.sv
// types shared by the sequencer and its bench
// assumes: mcs_regs.svh sits beside it
`include "mcs_regs.svh"
package mcs_pkg;
   // the eight intervals of one microinstruction cycle
   typedef enum logic [2:0] {
      IV_T1, IV_T2, IV_T3, IV_T4, IV_T5, IV_T6, IV_T7, IV_T8
   } mcs_ival_t;
   // four two-way lines: value and active-low enable
   typedef struct packed {
      logic [3:0] val;
      logic [3:0] oeN;
   } mcs_bus4_t;
   // one two-way line: value and active-low enable
   typedef struct packed {
      logic val;
      logic oeN;
   } mcs_pin_t;
endpackage

// ### test/mcs_far_side.sv
// far side model: register/ALU slice, interface logic unit, condition mux
// assumes: the interval is read from the phase outputs of the sequencer
`timescale 1ns/1ps
`default_nettype none

module mcs_far_side
   import mcs_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // sequencer pins
   input wire logic [3:0] phaseN,
   input wire mcs_bus4_t dataFlagAddrOut,
   input wire mcs_pin_t multiUnitEnableOut,
   input wire mcs_pin_t highCarryShiftOut,
   input wire mcs_pin_t lowCarryShiftOut,
   // scenario knobs
   input wire logic condN,
   input wire logic [8:0] dataVal,
   input wire logic shiftData,
   input wire logic foreignFetch,
   input wire logic hiFault,
   // resolved lines
   output logic [3:0] dataFlagAddrIn,
   output logic [3:0] dataExtensionIn,
   output logic jumpConditionN,
   output logic multiUnitEnableIn,
   output logic highCarryShiftIn,
   output logic lowCarryShiftIn,
   output logic [3:0] flagAddr
);
   logic [2:0] lastOddQ;
   logic [2:0] oddIdx;
   logic [2:0] ivl;
   logic togQ;
   logic inT7;
   assign oddIdx = !phaseN[0] ? 3'h0 : !phaseN[1] ? 3'h2 : !phaseN[2] ? 3'h4 : 3'h6;
   assign ivl = (phaseN != 4'hf) ? oddIdx : lastOddQ + 3'h1;
   assign inT7 = ivl[2] & ivl[1];
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lastOddQ <= 3'h0;
         togQ <= 1'b0;
         flagAddr <= 4'h0;
      end else begin
         togQ <= ~togQ;
         if (phaseN != 4'hf)
            lastOddQ <= oddIdx;
         if (ivl == 3'h0)
            flagAddr <= dataFlagAddrIn;
      end
   end
   // data valid in seven and eight
   assign dataFlagAddrIn = (~dataFlagAddrOut.oeN & dataFlagAddrOut.val) |
      (dataFlagAddrOut.oeN & (inT7 ? dataVal[3:0] : {4{togQ}}));
   assign dataExtensionIn = inT7 ? dataVal[7:4] : {4{togQ}};
   assign jumpConditionN = (ivl < 3'h2) ? condN : inT7 ? dataVal[8] : togQ;
   assign multiUnitEnableIn = (~multiUnitEnableOut.oeN & multiUnitEnableOut.val) |
      (foreignFetch & (ivl >= 3'h1) & (ivl <= 3'h3));
   assign highCarryShiftIn = !highCarryShiftOut.oeN ? highCarryShiftOut.val :
      (ivl == 3'h2) ? ~hiFault : inT7 ? shiftData : togQ;
   assign lowCarryShiftIn = !lowCarryShiftOut.oeN ? lowCarryShiftOut.val :
      (ivl == 3'h1 || ivl == 3'h2) ? 1'b1 : inT7 ? shiftData : togQ;
endmodule

`default_nettype wire

// ### test/mcs_sequencer_bench.sv
// bench of the pin sequencer: one task per scenario
// assumes: mcs_pkg and mcs_far_side compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"

module mcs_sequencer_bench
   import mcs_pkg::*;
;
   logic clock = 1'b0;
   logic rstn, ce, regWr, regRd, condN, shiftData, foreignFetch, hiFault;
   logic jumpConditionN, multiUnitEnableIn, highCarryShiftIn, lowCarryShiftIn, flagStrobeN;
   logic [3:0] regAddr, phaseN, commandBusN, dataFlagAddrIn, dataExtensionIn, flagAddr;
   logic [15:0] regWdata, regRdata;
   logic [8:0] dataVal;
   mcs_bus4_t dataFlagAddrOut;
   mcs_pin_t multiUnitEnableOut, highCarryShiftOut, lowCarryShiftOut;
   int errors = 0;
   int n_checks = 0;

   always #2 clock = ~clock;

   mcs_sequencer dut (.clock, .rstn, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .phaseN, .commandBusN, .dataFlagAddrIn, .dataFlagAddrOut, .dataExtensionIn,
      .jumpConditionN, .multiUnitEnableIn, .multiUnitEnableOut, .flagStrobeN,
      .highCarryShiftIn, .highCarryShiftOut, .lowCarryShiftIn, .lowCarryShiftOut);

   mcs_far_side far (.clock, .rstn, .phaseN, .dataFlagAddrOut, .multiUnitEnableOut,
      .highCarryShiftOut, .lowCarryShiftOut, .condN, .dataVal, .shiftData, .foreignFetch,
      .hiFault, .dataFlagAddrIn, .dataExtensionIn, .jumpConditionN, .multiUnitEnableIn,
      .highCarryShiftIn, .lowCarryShiftIn, .flagAddr);

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask

   task automatic wait_t1();
      int i;
      int j;
      i = 0;
      j = 0;
      while (phaseN === 4'he && i < 100) begin
         @(posedge clock);
         #1;
         i++;
      end
      while (phaseN !== 4'he && j < 600) begin
         @(posedge clock);
         #1;
         j++;
      end
      if (i >= 100 || j >= 600) begin
         chk("waitT1", 1'b1, 1'b0);
         end_sim();
      end
   endtask

   task automatic t_reset();
      logic [15:0] v;
      @(posedge clock);
      rstn <= 1'b0;
      @(posedge clock);
      #1;
      chk("rstPhase", phaseN, 4'hf);
      chk("rstCmd", commandBusN, 4'h0);
      chk("rstFlag", flagStrobeN, 1'b1);
      chk("rstOeN", {dataFlagAddrOut.oeN, multiUnitEnableOut.oeN, highCarryShiftOut.oeN,
         lowCarryShiftOut.oeN}, 7'h7f);
      @(posedge clock);
      rstn <= 1'b1;
      rd(`MCS_ADDR_CTRL, v);
      chk("ctrlRst", v, `MCS_CTRL_RST);
      rd(`MCS_ADDR_CMD, v);
      chk("cmdRst", v, `MCS_CMD_RST);
      rd(`MCS_ADDR_STAT, v);
      chk("statRst", v, 16'h0008);
      rd(4'h7, v);
      chk("unmapped", v, 16'h0000);
   endtask

   task automatic run_cyc(input logic [15:0] cmd, input logic [15:0] ctl, input logic cn,
      input logic [8:0] dat, input logic sd);
      logic [15:0] v;
      logic hiD, loD, hiV, loV;
      @(posedge clock);
      condN <= cn;
      dataVal <= dat;
      shiftData <= sd;
      wr(`MCS_ADDR_CMD, cmd);
      wr(`MCS_ADDR_CTRL, ctl);
      wr(`MCS_ADDR_STAT, 16'h0003);
      wait_t1();
      for (int k = 0; k < 8; k++) begin
         repeat (30) @(posedge clock);
         #1;
         hiD = k < 2 || k == 5 || (k > 5 && ctl[5] && ctl[7]);
         loD = k == 3 || k == 4 || k == 5 || (k > 5 && ctl[5] && !ctl[7]);
         hiV = k == 0 ? ctl[9] : (k > 5 && ctl[6]) ? sd : 1'b1;
         loV = k < 5 ? ctl[8] : (k > 5 && ctl[6]) ? sd : 1'b1;
         chk("phase", phaseN, 4'(k % 2 ? 4'hf : ~(4'h1 << (k / 2))));
         chk("cmdBus", commandBusN, 4'(k % 2 ? 4'h0 : ~cmd[4 * (k / 2) +: 4]));
         chk("flag", flagStrobeN, !((k == 1 && ctl[1]) || (k == 5 && ctl[2])));
         chk("diOeN", dataFlagAddrOut.oeN, k == 0 ? 4'h0 : 4'hf);
         if (k == 0)
            chk("diVal", dataFlagAddrOut.val, ctl[15:12]);
         chk("enOeN", multiUnitEnableOut.oeN, !(k > 0 && k < 4 && ctl[3]));
         chk("hiOeN", highCarryShiftOut.oeN, !hiD);
         chk("loOeN", lowCarryShiftOut.oeN, !loD);
         if (hiD)
            chk("hiVal", highCarryShiftOut.val, hiV);
         if (loD)
            chk("loVal", lowCarryShiftOut.val, loV);
         repeat (33) @(posedge clock);
      end
      chk("flagAddr", flagAddr, ctl[15:12]);
      rd(`MCS_ADDR_ILATCH, v);
      chk("ilatch", v, {7'h00, dat});
      rd(`MCS_ADDR_STAT, v);
      chk("stat", v[3:0], {1'b1, ctl[4] & ~cn, 1'b0, ctl[3]});
   endtask

   task automatic t_cycles();
      run_cyc(16'h7a18, 16'h5233, 1'b0, 9'h1a5, 1'b0);
      run_cyc(16'h0ff0, 16'ha5fd, 1'b1, 9'h05a, 1'b0);
      run_cyc(16'hffff, 16'hf367, 1'b0, 9'h1ff, 1'b0);
      run_cyc(16'h8421, 16'h00b1, 1'b0, 9'h100, 1'b1);
   endtask

   task automatic t_hierr();
      logic [15:0] v;
      @(posedge clock);
      hiFault <= 1'b1;
      wait_t1();
      wait_t1();
      @(posedge clock);
      hiFault <= 1'b0;
      rd(`MCS_ADDR_STAT, v);
      chk("hiErr", v[1], 1'b1);
      wr(`MCS_ADDR_STAT, 16'h0002);
      rd(`MCS_ADDR_STAT, v);
      chk("hiErrClr", v[1], 1'b0);
   endtask

   task automatic t_foreign();
      logic [15:0] v;
      logic [3:0] ph;
      @(posedge clock);
      foreignFetch <= 1'b1;
      wr(`MCS_ADDR_CTRL, 16'h0401);
      wait_t1();
      wait_t1();
      rd(`MCS_ADDR_STAT, v);
      chk("fetchImpl", {v[3], v[0]}, 2'b11);
      wr(`MCS_ADDR_STAT, 16'h0001);
      wr(`MCS_ADDR_CTRL, 16'h0001);
      repeat (1008) @(posedge clock);
      #1;
      ph = phaseN;
      rd(`MCS_ADDR_STAT, v);
      chk("fetchOff", {v[3], v[0]}, 2'b01);
      repeat (100) @(posedge clock);
      #1;
      chk("frozen", phaseN, ph);
      @(posedge clock);
      foreignFetch <= 1'b0;
      wr(`MCS_ADDR_STAT, 16'h0001);
      wr(`MCS_ADDR_CTRL, 16'h0001);
      rd(`MCS_ADDR_STAT, v);
      chk("reEnable", {v[3], v[0]}, 2'b10);
   endtask

   task automatic t_freeze();
      logic [15:0] v;
      logic [3:0] ph;
      @(posedge clock);
      ce <= 1'b0;
      @(posedge clock);
      #1;
      ph = phaseN;
      wr(`MCS_ADDR_CMD, 16'h1234);
      repeat (100) @(posedge clock);
      #1;
      chk("cePhase", phaseN, ph);
      @(posedge clock);
      ce <= 1'b1;
      rd(`MCS_ADDR_CMD, v);
      chk("ceCmd", v, 16'h8421);
   endtask

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
      condN = 1'b1;
      dataVal = 9'h000;
      shiftData = 1'b0;
      foreignFetch = 1'b0;
      hiFault = 1'b0;
      t_reset();
      t_cycles();
      t_hierr();
      t_foreign();
      t_freeze();
      t_reset();
      end_sim();
   end
endmodule

`default_nettype wire
